// ---- rtl/see_pkg.sv ----
// Operation
// - Array holds 1024, 2048 or 4096 sixteen-bit words, set by address width.
// - Data input is sampled on each serial clock rise while select is high.
// - Read data changes on serial clock rises.
// - Data output floats unless it drives read data or busy/ready.
// - Reset clears the write enable latch.
// - Writes are ignored while the enable latch is clear.
// - The enable latch stays set until the disable command or reset; opcode 11 with upper address bits 00 clears it too.
// - Reads work whatever the enable latch holds.
// - Falling select after a write launches self-timed programming.
// - Status reads 0 while programming and 1 once ready.
// - Status is driven only while select is high.
// - Status stays on the output until the next start bit.
// - Instruction is start bit 1, 2-bit opcode, address, msb first.
// - Opcode 10 reads, 01 writes sixteen data bits msb first.
// - Opcode 00 with upper address bits 11 sets the enable latch.
// - Opcode 00 with upper address bits 00 clears the enable latch.
// - A leading 0 before the start bit is accepted.
// - Programming, erase included, ends within 8 ms then reports ready; the code has no erase, opcode 11 acts only on the enable latch.
// - Reads advance the word address to stream following words.
// - A dummy 0 bit precedes the sixteen read data bits.
// - The read address wraps from the top word to zero.
package see_pkg;

	localparam int          WORD_WIDTH      = 16;
	localparam int          ADDR_WIDTH_DEF  = 10;
	localparam int          COUNT_WIDTH     = 5;
	localparam int          FIFO_DEPTH      = 8;
	localparam int          CLOCK_PERIOD_NS = 8;
	localparam int          PROG_TIME_MS    = 8;
	localparam int          PROG_CYCLES_DEF = PROG_TIME_MS * 1000000 / CLOCK_PERIOD_NS;
	localparam logic [1:0]  OPCODE_READ     = 2'h2;
	localparam logic [1:0]  OPCODE_WRITE    = 2'h1;
	localparam logic [1:0]  OPCODE_SPECIAL  = 2'h0;
	localparam logic [1:0]  SUB_ENABLE      = 2'h3;
	localparam logic [1:0]  SUB_DISABLE     = 2'h0;
	localparam logic [1:0]  SUB_WRITE_ALL   = 2'h1;
	localparam logic [4:0]  OPCODE_LAST_BIT = 5'h01;
	localparam logic [4:0]  WORD_LAST_BIT   = 5'h0f;
	localparam logic [15:0] WORD_ERASED     = 16'hffff;
	localparam logic        LATCH_RESET     = 1'h0;

	typedef enum logic [2:0] {
		ST_START  = 3'h0,
		ST_OPCODE = 3'h1,
		ST_ADDR   = 3'h2,
		ST_WDATA  = 3'h3,
		ST_READ   = 3'h4,
		ST_LAUNCH = 3'h5,
		ST_DONE   = 3'h6
	} see_phase_type;

endpackage : see_pkg

// ---- rtl/see_fifo.sv ----
`timescale 1ns/1ns
module see_fifo
	import see_pkg::*;
#(
	parameter int WIDTH = 26,
	parameter int DEPTH = FIFO_DEPTH
) (
	input  wire logic             clock,
	input  wire logic             reset_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] slot;
		logic [PW-1:0]               wr;
		logic [PW-1:0]               rd;
		logic [PW:0]                 count;
	} see_fifo_state_type;

	see_fifo_state_type s;
	see_fifo_state_type n;
	logic               push;
	logic               pop;

	assign in_ready  = s.count != (PW + 1)'(DEPTH);
	assign out_valid = s.count != '0;
	assign out_data  = s.slot[s.rd];

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		n    = s;
		push = in_valid & in_ready;
		pop  = out_valid & out_ready;
		if (push) begin
			n.slot[s.wr] = in_data;
			n.wr         = s.wr + 1'b1;
		end
		if (pop) begin
			n.rd = s.rd + 1'b1;
		end
		if (push & ~pop) begin
			n.count = s.count + 1'b1;
		end else if (pop & ~push) begin
			n.count = s.count - 1'b1;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

endmodule : see_fifo

// ---- rtl/see_eeprom.sv ----
`timescale 1ns/1ns
module see_eeprom
	import see_pkg::*;
#(
	parameter int ADDR_WIDTH  = ADDR_WIDTH_DEF,
	parameter int PROG_CYCLES = PROG_CYCLES_DEF
) (
	input  wire logic clock,
	input  wire logic reset_n,
	input  wire logic chip_select,
	input  wire logic serial_clock_pin,
	input  wire logic serial_data_in,
	output logic      serial_data_out,
	output logic      serial_data_out_en,
	output logic      programming_busy,
	output logic      write_enabled
);
	localparam int WORDS = 1 << ADDR_WIDTH;
	localparam int TW    = $clog2(PROG_CYCLES + 1);
	localparam int FW    = ADDR_WIDTH + WORD_WIDTH;

	typedef struct packed {
		logic [1:0]                             cs_sync;
		logic [1:0]                             sk_sync;
		logic [1:0]                             di_sync;
		logic                                   sk_prev;
		see_phase_type                          phase;
		logic [COUNT_WIDTH-1:0]                 bit_count;
		logic [1:0]                             opcode;
		logic [ADDR_WIDTH-1:0]                  addr;
		logic [WORD_WIDTH-1:0]                  shift;
		logic                                   enable_latch;
		logic                                   show_status;
		logic                                   dout;
		logic                                   dout_en;
		logic                                   busy;
		logic                                   prog_active;
		logic [TW-1:0]                          timer;
		logic [ADDR_WIDTH-1:0]                  prog_addr;
		logic [WORD_WIDTH-1:0]                  prog_data;
		logic [WORDS-1:0][WORD_WIDTH-1:0]       mem;
	} see_state_type;

	see_state_type         s;
	see_state_type         n;
	logic                  cs;
	logic                  di;
	logic                  rise;
	logic                  busy_now;
	logic                  push_valid;
	logic [FW-1:0]         push_data;
	logic                  fifo_in_ready;
	logic                  fifo_out_valid;
	logic                  fifo_out_ready;
	logic [FW-1:0]         fifo_out_data;
	logic [ADDR_WIDTH-1:0] addr_new;
	logic [1:0]            sub_code;

	assign serial_data_out    = s.dout;
	assign serial_data_out_en = s.dout_en;
	assign programming_busy   = s.busy;
	assign write_enabled      = s.enable_latch;

	////////////////////////////////////////////////////////////////////////////
	// Words waiting to be programmed queue here ahead of the timer.
	see_fifo #(
		.WIDTH (FW),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clock     (clock),
		.reset_n   (reset_n),
		.in_valid  (push_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (push_data),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (fifo_out_data)
	);

	assign fifo_out_ready = ~s.prog_active;

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		n          = s;
		n.cs_sync  = {s.cs_sync[0], chip_select};
		n.sk_sync  = {s.sk_sync[0], serial_clock_pin};
		n.di_sync  = {s.di_sync[0], serial_data_in};
		n.sk_prev  = s.sk_sync[1];
		cs         = s.cs_sync[1];
		di         = s.di_sync[1];
		rise       = s.sk_sync[1] & ~s.sk_prev;
		busy_now   = s.prog_active | fifo_out_valid;
		push_valid = 1'b0;
		push_data  = {s.addr, s.shift};
		addr_new   = {s.addr[ADDR_WIDTH-2:0], di};
		sub_code   = addr_new[ADDR_WIDTH-1:ADDR_WIDTH-2];

		// Decoder and shifter on the sampled serial link.
		if (!cs) begin
			if (s.phase == ST_LAUNCH) begin
				push_valid    = 1'b1;
				n.show_status = 1'b1;
			end
			n.phase = ST_START;
		end else if (rise) begin
			unique case (s.phase)
				ST_START: begin
					if (di) begin
						n.show_status = 1'b0;
						n.bit_count   = '0;
						n.phase       = busy_now ? ST_DONE : ST_OPCODE;
					end
				end
				ST_OPCODE: begin
					n.opcode = {s.opcode[0], di};
					if (s.bit_count == OPCODE_LAST_BIT) begin
						n.bit_count = '0;
						n.phase     = ST_ADDR;
					end else begin
						n.bit_count = s.bit_count + 1'b1;
					end
				end
				ST_ADDR: begin
					n.addr = addr_new;
					if (s.bit_count == COUNT_WIDTH'(ADDR_WIDTH - 1)) begin
						n.bit_count = '0;
						n.phase     = ST_DONE;
						if (s.opcode == OPCODE_READ) begin
							n.shift = s.mem[addr_new];
							n.dout  = 1'b0;
							n.phase = ST_READ;
						end else if (s.opcode == OPCODE_WRITE) begin
							n.phase = ST_WDATA;
						end else if (sub_code == SUB_ENABLE) begin
							n.enable_latch = 1'b1;
						end else if (sub_code == SUB_DISABLE) begin
							n.enable_latch = 1'b0;
						end
						// Write-all falls through to ST_DONE untouched.
					end else begin
						n.bit_count = s.bit_count + 1'b1;
					end
				end
				ST_WDATA: begin
					n.shift = {s.shift[WORD_WIDTH-2:0], di};
					if (s.bit_count == WORD_LAST_BIT) begin
						n.phase = (s.enable_latch & fifo_in_ready) ? ST_LAUNCH : ST_DONE;
					end else begin
						n.bit_count = s.bit_count + 1'b1;
					end
				end
				ST_READ: begin
					n.dout = s.shift[WORD_WIDTH-1];
					if (s.bit_count == WORD_LAST_BIT) begin
						n.addr      = s.addr + 1'b1;
						n.shift     = s.mem[s.addr + 1'b1];
						n.bit_count = '0;
					end else begin
						n.shift     = {s.shift[WORD_WIDTH-2:0], 1'b0};
						n.bit_count = s.bit_count + 1'b1;
					end
				end
				ST_LAUNCH: begin
					n.phase = ST_LAUNCH;
				end
				ST_DONE: begin
					n.phase = ST_DONE;
				end
			endcase
		end

		// Self-timed programming, one queued word at a time.
		if (s.prog_active) begin
			if (s.timer == '0) begin
				n.mem[s.prog_addr] = s.prog_data;
				n.prog_active      = 1'b0;
			end else begin
				n.timer = s.timer - 1'b1;
			end
		end else if (fifo_out_valid) begin
			n.prog_active = 1'b1;
			n.timer       = TW'(PROG_CYCLES - 1);
			n.prog_addr   = fifo_out_data[FW-1:WORD_WIDTH];
			n.prog_data   = fifo_out_data[WORD_WIDTH-1:0];
		end
		n.busy = n.prog_active | busy_now | push_valid;

		// Output pin drive.
		if (n.show_status && n.phase != ST_READ) begin
			n.dout = ~busy_now;
		end
		n.dout_en = cs & ((n.phase == ST_READ) | n.show_status);
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			s              <= '0;
			s.enable_latch <= LATCH_RESET;
			s.mem          <= {WORDS{WORD_ERASED}};
		end else begin
			s <= n;
		end
	end

endmodule : see_eeprom

// ---- bench/see_eeprom_sva.sv ----
`timescale 1ns/1ns
module see_eeprom_sva
	import see_pkg::*;
#(
	parameter int ADDR_WIDTH  = ADDR_WIDTH_DEF,
	parameter int PROG_CYCLES = PROG_CYCLES_DEF
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic chip_select,
	input wire logic serial_clock_pin,
	input wire logic serial_data_in,
	input wire logic serial_data_out,
	input wire logic serial_data_out_en,
	input wire logic programming_busy,
	input wire logic write_enabled
);
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	logic [31:0] busy_count;
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			busy_count <= '0;
		else
			busy_count <= programming_busy ? busy_count + 32'h1 : '0;
	end
	////////////////////////////////////////////////////////////////////////////////
	chk_float_deselect: assert property (!chip_select [*6] |-> !serial_data_out_en)
		else $error("data output driven while deselected");
	chk_latch_select: assert property ($changed(write_enabled) |-> $past(chip_select, 2))
		else $error("latch changed outside an instruction");
	chk_busy_latch: assert property ($rose(programming_busy) |-> write_enabled)
		else $error("programming started with latch clear");
	chk_busy_launch: assert property ($rose(programming_busy) |-> !chip_select)
		else $error("programming started with select high");
	chk_prog_bound: assert property (programming_busy |-> busy_count <= PROG_CYCLES + 16)
		else $error("programming too long");
	chk_status_busy: assert property (programming_busy && $past(programming_busy, 3)
		&& serial_data_out_en |-> !serial_data_out)
		else $error("status not busy");
	chk_ready_shown: assert property ($fell(programming_busy) && serial_data_out_en
		|-> ##[1:2] serial_data_out)
		else $error("ready not shown");
	chk_read_on_sk: assert property ($changed(serial_data_out) && serial_data_out_en
		&& $past(serial_data_out_en) && !$past(programming_busy)
		&& !$past(programming_busy, 2) |-> serial_clock_pin)
		else $error("read data moved without clock rise");
	cover property ($rose(write_enabled));
	cover property ($rose(programming_busy));
	cover property ($fell(programming_busy) && serial_data_out_en);
endmodule : see_eeprom_sva
bind see_eeprom see_eeprom_sva #(.ADDR_WIDTH(ADDR_WIDTH), .PROG_CYCLES(PROG_CYCLES)) chk (
	.clock(clock), .reset_n(reset_n), .chip_select(chip_select),
	.serial_clock_pin(serial_clock_pin), .serial_data_in(serial_data_in),
	.serial_data_out(serial_data_out), .serial_data_out_en(serial_data_out_en),
	.programming_busy(programming_busy), .write_enabled(write_enabled));

// ---- bench/see_host.sv ----
`timescale 1ns/1ns
module see_host (
	input  wire logic clock,
	output logic      chip_select,
	output logic      serial_clock_pin,
	output logic      serial_data_in,
	input  wire logic serial_data_out
);
	logic [47:0] rx;
	initial begin
		chip_select = 0;
		serial_clock_pin = 0;
		serial_data_in = 0;
		rx = '0;
	end
	// Sends n bits msb first, a leading 0 or the start bit 1 first; the write-all encoding is never sent.
	task automatic cmd(input int n, input logic [47:0] v);
		@(negedge clock);
		chip_select = 1;
		repeat (8) @(negedge clock);
		for (int i = n - 1; i >= 0; i--) begin
			serial_data_in = v[i];
			repeat (8) @(negedge clock);
			serial_clock_pin = 1;
			repeat (8) @(negedge clock);
			rx = {rx[46:0], serial_data_out};
			serial_clock_pin = 0;
		end
		chip_select = 0;
		serial_data_in = ~serial_data_in;
		repeat (32) @(negedge clock);
	endtask : cmd
	task automatic sel(input logic v);
		@(negedge clock);
		chip_select = v;
	endtask : sel
endmodule : see_host

// ---- bench/see_eeprom_bench.sv ----
`timescale 1ns/1ns
module see_eeprom_bench;
	import see_pkg::*;
	logic clock   = 0;
	logic reset_n = 0;
	wire logic cs, sk, di;
	logic dout, dout_en, busy, wen;
	wire logic do_pin;
	int   n_fail = 0;
	int   samples_checked = 0;
	int   cycles = 0;
	always #4 clock = ~clock;
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_fail++;
			stop_test();
		end
	end
	// A released data pin has no pull resistor, so the host sees the inverse of the last bit.
	assign do_pin = dout_en ? dout : ~dout;
	see_host host (.clock(clock), .chip_select(cs), .serial_clock_pin(sk),
		.serial_data_in(di), .serial_data_out(do_pin));
	see_eeprom #(.ADDR_WIDTH(10), .PROG_CYCLES(200)) dut (.clock(clock), .reset_n(reset_n),
		.chip_select(cs), .serial_clock_pin(sk), .serial_data_in(di),
		.serial_data_out(dout), .serial_data_out_en(dout_en),
		.programming_busy(busy), .write_enabled(wen));
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [32:0] seen, input logic [32:0] exp, input string what);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t %s", $time, what);
		end
	endtask : check
	task automatic stop_test();
		$display("checked %0d failed %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : stop_test
	task automatic t_locked();
		check(wen, 0, "latch after reset");
		check(dout_en, 0, "idle float");
		host.cmd(29, {3'b101, 10'h005, 16'h1234});
		check(busy, 0, "locked write");
		host.cmd(45, {3'b110, 10'h005, 32'h0});
		check(host.rx[32:16], {1'b0, WORD_ERASED}, "locked read");
		$display("t_locked done");
	endtask : t_locked
	task automatic t_write();
		int w;
		host.cmd(14, {4'b0100, 10'h300});
		check(wen, 1, "enable");
		host.cmd(8, 8'h80);
		check(wen, 1, "abort");
		host.cmd(29, {3'b101, 10'h3ff, 16'ha5c3});
		check(busy, 1, "launch");
		host.sel(1);
		repeat (8) @(negedge clock);
		check({dout_en, dout}, 2'b10, "busy status");
		for (w = 0; w < 400 && do_pin !== 1'b1; w++)
			@(negedge clock);
		check({dout_en, dout, busy}, 3'b110, "ready");
		host.sel(0);
		repeat (32) @(negedge clock);
		check(dout_en, 0, "status float");
		host.cmd(45, {3'b110, 10'h3ff, 32'h0});
		check(host.rx[32:0], {1'b0, 16'ha5c3, WORD_ERASED}, "stream");
		host.cmd(29, {3'b101, 10'h001, 16'h0f0f});
		host.cmd(13, {3'b100, 10'h000});
		check(wen, 1, "ignored while busy");
		host.cmd(45, {3'b110, 10'h001, 32'h0});
		check(host.rx[32:16], {1'b0, 16'h0f0f}, "second word");
		host.cmd(13, {3'b100, 10'h000});
		check(wen, 0, "disable");
		$display("t_write done");
	endtask : t_write
	initial begin
		repeat (20) @(negedge clock);
		reset_n = 1;
		repeat (4) @(negedge clock);
		t_locked();
		t_write();
		stop_test();
	end
endmodule : see_eeprom_bench
